//--- hw/receiver_gain_config_regs.vh
/*
 constants for the receive configuration register bank: offsets, field
 positions, reset values and timing counts. assumes a 200 MHz clock.
*/
// What this block does
// - register at 0Bh, resets with gain control, whole-period mode, auto squelch set
// - all three registers reload defaults at power-up and restore-defaults command
// - bit 6 selects differential or split LF inputs to AM and PM
// - bit 3 chooses first eight pulses or whole receive period for gain control
// - bit 2 chooses preset or reset gain control algorithm
// - auto squelch starts 18.88 us after transmit ends, stops at mask timer expiry
// - bit 0 picks mixer clock; single-ended mode always uses internal signal
// - bit 7 puts receiver in low power, bit 5 applies LF to input
// - 0Ch holds AM and PM first-stage gain codes: full, cut steps, boost
// - bit 1 of 0Ch clips first and second stage outputs
// - bit 0 of 0Ch forces -6 dB and widest window; clearing needs receiver restart
// - codes 1h-4h widen digitizer window, 5h-Ah also cut later-stage gain
// - 0Dh values reach gain logic only after reset-receive-gain or restore-defaults command
`ifndef RECEIVER_GAIN_CONFIG_REGS_VH
`define RECEIVER_GAIN_CONFIG_REGS_VH

`define ADDR_RECEIVER_CONTROL_TWO 8'h0b
`define ADDR_FIRST_STAGE_GAIN     8'h0c
`define ADDR_LATER_STAGE_GAIN     8'h0d

`define RESET_RECEIVER_CONTROL_TWO 8'h1a
`define RESET_FIRST_STAGE_GAIN     8'hd8
`define RESET_LATER_STAGE_GAIN     8'h00

`define BIT_LOW_POWER_RECEIVE      7
`define BIT_LOWFREQ_INPUT_SPLIT    6
`define BIT_LOWFREQ_ENABLE         5
`define BIT_GAIN_CONTROL_ENABLE    4
`define BIT_GAIN_WHOLE_PERIOD      3
`define BIT_GAIN_RESET_ALGORITHM   2
`define BIT_AUTO_SQUELCH           1
`define BIT_PHASE_MIXER_CLOCK      0
`define MSB_AM_FIRST_STAGE         7
`define LSB_AM_FIRST_STAGE         5
`define MSB_PM_FIRST_STAGE         4
`define LSB_PM_FIRST_STAGE         2
`define BIT_CLIP_STAGES            1
`define BIT_FORCED_PEER_GAIN_MODE  0
`define MSB_AM_LATER_STAGE         7
`define LSB_AM_LATER_STAGE         4
`define MSB_PM_LATER_STAGE         3
`define LSB_PM_LATER_STAGE         0

`define FIRST_STAGE_BOOST_CODE     3'h7
`define LATER_STAGE_WINDOW_LAST    4'h4
`define LATER_STAGE_CODE_LAST      4'ha

// squelch delay after transmit end
`define SQUELCH_DELAY_PS   18880000
`define CLOCK_PERIOD_PS    5000
`define SQUELCH_DELAY_CYCLES ((`SQUELCH_DELAY_PS + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)

`endif

//--- hw/squelch_timer.v
/*
 squelch window timer: starts squelch a fixed delay after transmit ends
 and holds it until the mask receive timer expires.
 assumes synchronous pulse inputs and an already synchronised reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "receiver_gain_config_regs.vh"
module squelch_timer #(
   parameter DELAY = `SQUELCH_DELAY_CYCLES
) (
   // clock and reset
   input  wire clock,
   input  wire rstn,
   // control
   input  wire enable,
   input  wire transmitEnd,
   input  wire maskExpired,
   // result
   output reg  squelchActive
);
   reg [15:0] count;
   reg        waiting;

   //////////////////////////////////////////////////////////////////////
   // delayed squelch start
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count         <= 16'h0000;
         waiting       <= 1'b0;
         squelchActive <= 1'b0;
      end else if (!enable || maskExpired) begin
         count         <= 16'h0000;
         waiting       <= 1'b0;
         squelchActive <= 1'b0;
      end else if (transmitEnd) begin
         count         <= 16'h0001;
         waiting       <= 1'b1;
         squelchActive <= 1'b0;
      end else if (waiting) begin
         if (count == DELAY[15:0]) begin
            waiting       <= 1'b0;
            squelchActive <= 1'b1;
         end else begin
            count <= count + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

//--- hw/gain_code_decoder.v
/*
 decodes one channel's gain codes into stage controls.
 assumes codes held stable by the register bank.
*/
`timescale 1ns/10ps
`default_nettype none
`include "receiver_gain_config_regs.vh"
module gain_code_decoder (
   // codes
   input  wire [2:0] firstCode,
   input  wire [3:0] laterCode,
   input  wire       forcedPeer,
   // decoded
   output wire [2:0] firstCutSteps,
   output wire       firstBoost,
   output wire [2:0] windowSteps,
   output wire [2:0] laterCutSteps,
   output wire       forcedWide
);
   wire [3:0] clamped;
   wire [3:0] laterExcess;

   assign firstBoost    = (firstCode == `FIRST_STAGE_BOOST_CODE);
   assign firstCutSteps = firstBoost ? 3'h0 : firstCode;
   assign clamped = (laterCode > `LATER_STAGE_CODE_LAST) ? `LATER_STAGE_CODE_LAST : laterCode;
   assign windowSteps = (clamped > `LATER_STAGE_WINDOW_LAST) ? 3'h4 : clamped[2:0];
   // stage cut counts the steps above the last window-only code
   assign laterExcess   = clamped - `LATER_STAGE_WINDOW_LAST;
   assign laterCutSteps = (clamped > `LATER_STAGE_WINDOW_LAST) ? laterExcess[2:0] : 3'h0;
   assign forcedWide = forcedPeer;
endmodule
`default_nettype wire

//--- hw/receiver_gain_config_regs.v
/*
 receive configuration register bank with decoded analogue controls.
 assumes a synchronous host port, reads answered one cycle later.
*/
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "receiver_gain_config_regs.vh"
module receiver_gain_config_regs (
   // clock and reset
   input  wire       clock,
   input  wire       resetn,
   // host port
   input  wire [7:0] address,
   input  wire [7:0] writeData,
   input  wire       writeStrobe,
   input  wire       readStrobe,
   output reg  [7:0] readData,
   // direct commands and events
   input  wire       restoreDefaults,
   input  wire       resetReceiveGain,
   input  wire       transmitEnd,
   input  wire       maskExpired,
   input  wire       singleEndedMode,
   // receiver controls
   output reg        lowPowerReceive,
   output reg        lowfreqInputSplit,
   output reg        lowfreqEnable,
   output reg        gainControlEnable,
   output reg        gainWholePeriod,
   output reg        gainResetAlgorithm,
   output reg        squelchActive,
   output reg        phaseMixerInternal,
   output reg  [2:0] amFirstCut,
   output reg        amFirstBoost,
   output reg  [2:0] pmFirstCut,
   output reg        pmFirstBoost,
   output reg        clipStages,
   output reg        forcedPeerGainMode,
   output reg  [2:0] amWindowSteps,
   output reg  [2:0] amLaterCut,
   output reg  [2:0] pmWindowSteps,
   output reg  [2:0] pmLaterCut,
   output reg        receiverRestartNeeded
);
   reg        rstMeta;
   reg        rstn;
   reg  [7:0] receiverControlTwo;
   reg  [7:0] firstStageGain;
   reg  [7:0] laterStageGain;
   reg  [7:0] activeLaterGain;
   reg  [7:0] next_readData;
   wire       squelchNow;
   wire       forcedCleared;
   wire [2:0] amCutW;
   wire       amBoostW;
   wire [2:0] amWinW;
   wire [2:0] amLaterW;
   wire [2:0] pmCutW;
   wire       pmBoostW;
   wire [2:0] pmWinW;
   wire [2:0] pmLaterW;

   ////////////////////////////////////////////////////////////////////////
   // reset release
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstn    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstn    <= rstMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         receiverControlTwo <= `RESET_RECEIVER_CONTROL_TWO;
         firstStageGain     <= `RESET_FIRST_STAGE_GAIN;
         laterStageGain     <= `RESET_LATER_STAGE_GAIN;
      end else if (restoreDefaults) begin
         receiverControlTwo <= `RESET_RECEIVER_CONTROL_TWO;
         firstStageGain     <= `RESET_FIRST_STAGE_GAIN;
         laterStageGain     <= `RESET_LATER_STAGE_GAIN;
      end else if (writeStrobe) begin
         if (address == `ADDR_RECEIVER_CONTROL_TWO) begin
            receiverControlTwo <= writeData;
         end else if (address == `ADDR_FIRST_STAGE_GAIN) begin
            firstStageGain <= writeData;
         end else if (address == `ADDR_LATER_STAGE_GAIN) begin
            laterStageGain <= writeData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // load later-stage gain
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         activeLaterGain <= `RESET_LATER_STAGE_GAIN;
      end else if (restoreDefaults) begin
         activeLaterGain <= `RESET_LATER_STAGE_GAIN;
      end else if (resetReceiveGain) begin
         activeLaterGain <= laterStageGain;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // restart after clearing forced mode
   assign forcedCleared = firstStageGain[`BIT_FORCED_PEER_GAIN_MODE] &&
                          (restoreDefaults ||
                           (writeStrobe && address == `ADDR_FIRST_STAGE_GAIN &&
                            !writeData[`BIT_FORCED_PEER_GAIN_MODE]));

   // set wins over the gain command in the same cycle
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         receiverRestartNeeded <= 1'b0;
      end else if (forcedCleared) begin
         receiverRestartNeeded <= 1'b1;
      end else if (resetReceiveGain) begin
         receiverRestartNeeded <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path
   always @* begin
      next_readData = 8'h00;
      if (address == `ADDR_RECEIVER_CONTROL_TWO) begin
         next_readData = receiverControlTwo;
      end else if (address == `ADDR_FIRST_STAGE_GAIN) begin
         next_readData = firstStageGain;
      end else if (address == `ADDR_LATER_STAGE_GAIN) begin
         next_readData = laterStageGain;
      end
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         readData <= 8'h00;
      end else if (readStrobe) begin
         readData <= next_readData;
      end else begin
         readData <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // squelch and decoders
   squelch_timer u_squelch (
      .clock         (clock),
      .rstn          (rstn),
      .enable        (receiverControlTwo[`BIT_AUTO_SQUELCH]),
      .transmitEnd   (transmitEnd),
      .maskExpired   (maskExpired),
      .squelchActive (squelchNow)
   );

   gain_code_decoder u_am (
      .firstCode     (firstStageGain[`MSB_AM_FIRST_STAGE:`LSB_AM_FIRST_STAGE]),
      .laterCode     (activeLaterGain[`MSB_AM_LATER_STAGE:`LSB_AM_LATER_STAGE]),
      .forcedPeer    (firstStageGain[`BIT_FORCED_PEER_GAIN_MODE]),
      .firstCutSteps (amCutW),
      .firstBoost    (amBoostW),
      .windowSteps   (amWinW),
      .laterCutSteps (amLaterW),
      .forcedWide    ()
   );

   gain_code_decoder u_pm (
      .firstCode     (firstStageGain[`MSB_PM_FIRST_STAGE:`LSB_PM_FIRST_STAGE]),
      .laterCode     (activeLaterGain[`MSB_PM_LATER_STAGE:`LSB_PM_LATER_STAGE]),
      .forcedPeer    (firstStageGain[`BIT_FORCED_PEER_GAIN_MODE]),
      .firstCutSteps (pmCutW),
      .firstBoost    (pmBoostW),
      .windowSteps   (pmWinW),
      .laterCutSteps (pmLaterW),
      .forcedWide    ()
   );

   ////////////////////////////////////////////////////////////////////////
   // registered control outputs
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lowPowerReceive    <= 1'b0;
         lowfreqInputSplit  <= 1'b0;
         lowfreqEnable      <= 1'b0;
         gainControlEnable  <= 1'b0;
         gainWholePeriod    <= 1'b0;
         gainResetAlgorithm <= 1'b0;
         squelchActive      <= 1'b0;
         phaseMixerInternal <= 1'b0;
         amFirstCut         <= 3'h0;
         amFirstBoost       <= 1'b0;
         pmFirstCut         <= 3'h0;
         pmFirstBoost       <= 1'b0;
         clipStages         <= 1'b0;
         forcedPeerGainMode <= 1'b0;
         amWindowSteps      <= 3'h0;
         amLaterCut         <= 3'h0;
         pmWindowSteps      <= 3'h0;
         pmLaterCut         <= 3'h0;
      end else begin
         lowPowerReceive    <= receiverControlTwo[`BIT_LOW_POWER_RECEIVE];
         lowfreqEnable      <= receiverControlTwo[`BIT_LOWFREQ_ENABLE];
         lowfreqInputSplit  <= receiverControlTwo[`BIT_LOWFREQ_INPUT_SPLIT];
         gainControlEnable  <= receiverControlTwo[`BIT_GAIN_CONTROL_ENABLE];
         gainWholePeriod    <= receiverControlTwo[`BIT_GAIN_WHOLE_PERIOD];
         gainResetAlgorithm <= receiverControlTwo[`BIT_GAIN_RESET_ALGORITHM];
         squelchActive      <= squelchNow;
         phaseMixerInternal <= receiverControlTwo[`BIT_PHASE_MIXER_CLOCK] | singleEndedMode;
         amFirstCut         <= amCutW;
         amFirstBoost       <= amBoostW;
         pmFirstCut         <= pmCutW;
         pmFirstBoost       <= pmBoostW;
         clipStages         <= firstStageGain[`BIT_CLIP_STAGES];
         forcedPeerGainMode <= firstStageGain[`BIT_FORCED_PEER_GAIN_MODE];
         amWindowSteps      <= amWinW;
         amLaterCut         <= amLaterW;
         pmWindowSteps      <= pmWinW;
         pmLaterCut         <= pmLaterW;
      end
   end
endmodule
`default_nettype wire

//--- test/receiver_gain_config_regs_sva.sv
/* checker for the receive gain register bank.
   sees only top-level ports; bound from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module receiver_gain_config_regs_sva (
   // clock and reset
   input wire logic       clock,
   input wire logic       resetn,
   // host port
   input wire logic [7:0] address,
   input wire logic       readStrobe,
   input wire logic [7:0] readData,
   // commands
   input wire logic       restoreDefaults,
   input wire logic       resetReceiveGain,
   input wire logic       transmitEnd,
   input wire logic       maskExpired,
   input wire logic       singleEndedMode,
   // controls
   input wire logic       squelchActive,
   input wire logic       phaseMixerInternal,
   input wire logic [2:0] amFirstCut,
   input wire logic       amFirstBoost,
   input wire logic [2:0] amWindowSteps,
   input wire logic [2:0] amLaterCut,
   input wire logic [2:0] pmWindowSteps,
   input wire logic [2:0] pmLaterCut,
   input wire logic       forcedPeerGainMode,
   input wire logic       receiverRestartNeeded
);
   logic [2:0] upCount;
   logic [12:0] sinceTx;
   wire        up = (upCount == 3'h7);
   // skips the synchroniser lag after reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         upCount <= 3'h0;
      else if (!up)
         upCount <= upCount + 3'h1;
   end
   // cycles since the last end of transmit, saturating
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         sinceTx <= 13'h1fff;
      else if (transmitEnd)
         sinceTx <= 13'h0001;
      else if (sinceTx != 13'h1fff)
         sinceTx <= sinceTx + 13'h0001;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   a_read_idle_zero: assert property (up && !$past(readStrobe) |-> readData == 8'h00)
      else $error("readData not zero outside a read");
   a_unmapped_read: assert property (up && readStrobe && (address < 8'h0b || address > 8'h0d)
      |=> readData == 8'h00) else $error("unmapped read not zero");
   a_mixer_single: assert property (up && $past(singleEndedMode, 2) && $past(singleEndedMode)
      |-> phaseMixerInternal) else $error("mixer not internal in single mode");
   a_boost_no_cut: assert property (up && amFirstBoost |-> amFirstCut == 3'h0)
      else $error("boost with cut");
   a_later_window: assert property (up |-> (amLaterCut == 3'h0 || amWindowSteps == 3'h4)
      && (pmLaterCut == 3'h0 || pmWindowSteps == 3'h4)) else $error("later cut without wide window");
   a_later_hold: assert property (up && !$past(resetReceiveGain) && !$past(restoreDefaults)
      && !$past(resetReceiveGain, 2) && !$past(restoreDefaults, 2)
      |-> $stable({amWindowSteps, amLaterCut, pmWindowSteps, pmLaterCut}))
      else $error("later gain changed without command");
   a_squelch_delay: assert property (up && transmitEnd && !squelchActive
      |-> !squelchActive [*3]) else $error("squelch too early");
   a_squelch_start: assert property (up && $rose(squelchActive)
      |-> sinceTx == 13'hec2) else $error("squelch start not at delay");
   a_squelch_stop: assert property (up && maskExpired && !transmitEnd
      |-> ##[1:2] !squelchActive) else $error("squelch not stopped");
   a_restart_flag: assert property (up && $fell(forcedPeerGainMode) && !resetReceiveGain
      && !$past(resetReceiveGain)
      |-> ##[0:2] receiverRestartNeeded) else $error("restart flag not set");
   c_read: cover property (up && readStrobe);
   c_squelch: cover property (up && $rose(squelchActive));
   c_restart: cover property (up && $rose(receiverRestartNeeded));
endmodule
`default_nettype wire

//--- test/receiver_gain_config_regs_tb.sv
/* bench for the receive gain register bank: random and corner stimulus.
   assumes the checker module is compiled before this file. */
`timescale 1ns/10ps
`default_nettype none
module receiver_gain_config_regs_tb;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  address = 8'h00;
   logic [7:0]  writeData = 8'h00;
   logic        writeStrobe = 1'b0;
   logic        readStrobe = 1'b0;
   logic [3:0]  evt = 4'h0;
   logic        singleEndedMode = 1'b0;
   wire  [7:0]  readData;
   wire  [6:0]  ctl;
   wire  [2:0]  amFirstCut, pmFirstCut, amWindowSteps, amLaterCut, pmWindowSteps, pmLaterCut;
   wire         amFirstBoost, pmFirstBoost, clipStages, forcedPeerGainMode, restartNeeded;
   wire         restoreDefaults, resetReceiveGain, transmitEnd, maskExpired, squelchActive;
   logic [31:0] seed = 32'd15004;
   logic [7:0]  regs [3] = '{8'h1a, 8'hd8, 8'h00};
   logic [7:0]  act = 8'h00;
   logic        rn = 1'b0;
   int          fail_count = 0;
   int          checked = 0;
   localparam int squelchCycles = 18880 / 5;
   assign {restoreDefaults, resetReceiveGain, transmitEnd, maskExpired} = evt;
   always #2.5 clock = ~clock;
   receiver_gain_config_regs u_dut (
      .clock(clock), .resetn(resetn), .address(address), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
      .restoreDefaults(restoreDefaults), .resetReceiveGain(resetReceiveGain),
      .transmitEnd(transmitEnd), .maskExpired(maskExpired), .singleEndedMode(singleEndedMode),
      .lowPowerReceive(ctl[6]), .lowfreqInputSplit(ctl[5]), .lowfreqEnable(ctl[4]),
      .gainControlEnable(ctl[3]), .gainWholePeriod(ctl[2]), .gainResetAlgorithm(ctl[1]),
      .squelchActive(squelchActive), .phaseMixerInternal(ctl[0]),
      .amFirstCut(amFirstCut), .amFirstBoost(amFirstBoost), .pmFirstCut(pmFirstCut),
      .pmFirstBoost(pmFirstBoost), .clipStages(clipStages),
      .forcedPeerGainMode(forcedPeerGainMode), .amWindowSteps(amWindowSteps),
      .amLaterCut(amLaterCut), .pmWindowSteps(pmWindowSteps), .pmLaterCut(pmLaterCut),
      .receiverRestartNeeded(restartNeeded));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [3:0] fst(input logic [2:0] c);
      return {(c == 3'h7) ? 3'h0 : c, c == 3'h7};
   endfunction
   function automatic logic [5:0] later(input logic [3:0] c);
      return {(c > 4'h4) ? 3'h4 : c[2:0], (c > 4'h4) ? c[2:0] - 3'h4 : 3'h0};
   endfunction
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
      if (a == 8'h0c && regs[1][0] && !d[0])
         rn = 1'b1;
      if (a >= 8'h0b && a <= 8'h0d)
         regs[a - 8'h0b] = d;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1;
      cmp("readData", exp, readData);
   endtask
   task automatic pulse(input logic [3:0] e);
      @(posedge clock);
      evt <= e;
      @(posedge clock);
      evt <= 4'h0;
      if (e[2]) begin
         act = regs[2];
         rn = 1'b0;
      end
      if (e[3]) begin
         regs = '{8'h1a, 8'hd8, 8'h00};
         act = 8'h00;
      end
   endtask
   task automatic chkOut();
      repeat (2) @(posedge clock);
      #1;
      cmp("controls", {1'b0, regs[0][7:2], regs[0][0] | singleEndedMode}, {1'b0, ctl});
      cmp("firstGain", {fst(regs[1][7:5]), fst(regs[1][4:2])},
          {amFirstCut, amFirstBoost, pmFirstCut, pmFirstBoost});
      cmp("clipForced", {5'h00, regs[1][1:0], rn}, {5'h00, clipStages, forcedPeerGainMode, restartNeeded});
      cmp("amLater", {2'h0, later(act[7:4])}, {2'h0, amWindowSteps, amLaterCut});
      cmp("pmLater", {2'h0, later(act[3:0])}, {2'h0, pmWindowSteps, pmLaterCut});
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic [7:0]  a;
      logic [7:0]  d;
      int          cnt;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      for (int i = 0; i < 3; i++) rdchk(8'h0b + 8'(i), regs[i]);
      chkOut();
      wr(8'h0e, 8'hff);
      rdchk(8'h0e, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(8'h0c, {3'(i), 3'(7 - i), 2'(i)});
         chkOut();
      end
      wr(8'h0c, 8'h00);
      chkOut();
      pulse(4'h4);
      for (int i = 0; i < 11; i++) begin
         wr(8'h0d, {4'(i), 4'(10 - i)});
         chkOut();
         pulse(4'h4);
         chkOut();
      end
      for (int n = 0; n < 40; n++) begin
         r = rnd();
         @(posedge clock);
         singleEndedMode <= r[8];
         a = 8'h0b + {6'h00, r[1:0]};
         // later-stage codes kept within 0h to Ah
         d = (a == 8'h0d) ? {r[19:16] % 4'hb, r[23:20] % 4'hb} : r[23:16];
         wr(a, d);
         rdchk(a, (a == 8'h0e) ? 8'h00 : regs[a - 8'h0b]);
         if (r[9])
            pulse(4'h4);
         chkOut();
      end
      wr(8'h0b, 8'h1a);
      pulse(4'h2);
      cnt = 0;
      while (squelchActive !== 1'b1 && cnt < 4000) begin
         @(posedge clock);
         #1;
         cnt++;
      end
      cmp("squelchDelay", 8'h01, {7'h00, cnt >= squelchCycles && cnt <= squelchCycles + 2});
      if (squelchActive !== 1'b1)
         end_sim();
      pulse(4'h1);
      repeat (2) @(posedge clock);
      #1;
      cmp("squelchStop", 8'h00, {7'h00, squelchActive});
      wr(8'h0b, 8'h18);
      pulse(4'h2);
      repeat (8) @(posedge clock);
      #1;
      cmp("squelchOff", 8'h00, {7'h00, squelchActive});
      wr(8'h0b, 8'he5);
      wr(8'h0c, 8'h26);
      wr(8'h0d, 8'h9a);
      pulse(4'h4);
      pulse(4'h8);
      for (int i = 0; i < 3; i++) rdchk(8'h0b + 8'(i), regs[i]);
      chkOut();
      end_sim();
   end
endmodule
bind receiver_gain_config_regs receiver_gain_config_regs_sva u_sva (
   .clock(clock), .resetn(resetn), .address(address), .readStrobe(readStrobe),
   .readData(readData), .restoreDefaults(restoreDefaults), .resetReceiveGain(resetReceiveGain),
   .transmitEnd(transmitEnd), .maskExpired(maskExpired), .singleEndedMode(singleEndedMode),
   .squelchActive(squelchActive), .phaseMixerInternal(phaseMixerInternal),
   .amFirstCut(amFirstCut), .amFirstBoost(amFirstBoost), .amWindowSteps(amWindowSteps),
   .amLaterCut(amLaterCut), .pmWindowSteps(pmWindowSteps), .pmLaterCut(pmLaterCut),
   .forcedPeerGainMode(forcedPeerGainMode), .receiverRestartNeeded(receiverRestartNeeded));
`default_nettype wire
